// ==== bench/flash_host_model.sv ====
// host-side model: raises operation requests and suspend events
// assumes the bench calls its tasks between clock edges
`default_nettype none
module flash_host_model (
    // clock
    input wire logic sys_clk_in,
    // requests toward the block
    output var flash_protect_pkg::op_req_t op_req_out,
    output logic suspend_out,
    output logic resume_out,
    output logic erase_busy_out,
    output logic program_busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        op_req_out = '0;
        suspend_out = 1'b0;
        resume_out = 1'b0;
        erase_busy_out = 1'b0;
        program_busy_out = 1'b0;
    end
    // returns once the answer to the request stands
    task automatic issue(input flash_protect_pkg::op_kind_t k,
                         input logic [26:0] a);
        @(posedge sys_clk_in);
        op_req_out <= '{1'b1, k, a};
        @(posedge sys_clk_in);
        // released address is inverted so a stale value never looks valid
        op_req_out <= '{1'b0, flash_protect_pkg::OP_NONE, ~a};
        #1;
    endtask : issue
    task automatic suspend(input bit erase);
        @(posedge sys_clk_in);
        erase_busy_out <= erase;
        program_busy_out <= !erase;
        suspend_out <= 1'b1;
        @(posedge sys_clk_in);
        suspend_out <= 1'b0;
        #1;
    endtask : suspend
    task automatic resume;
        @(posedge sys_clk_in);
        resume_out <= 1'b1;
        @(posedge sys_clk_in);
        resume_out <= 1'b0;
        erase_busy_out <= 1'b0;
        program_busy_out <= 1'b0;
        #1;
    endtask : resume
endmodule : flash_host_model
`default_nettype wire

// ==== bench/test_flash_block_protect_decode.sv ====
// bench: both block-size options side by side on shared inputs
// assumes the host model drives requests; registers read on uut only
`default_nettype none
module test_flash_block_protect_decode;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] code = 4'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic s_acc, s_inh, s_none, l_acc, l_inh, l_none;
    logic [10:0] s_lo, s_hi, l_lo, l_hi;
    flash_protect_pkg::func_reg_t s_func, l_func;
    flash_protect_pkg::op_req_t req;
    logic sus, res, ebusy, pbusy;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    localparam flash_protect_pkg::op_kind_t PROG =
        flash_protect_pkg::OP_PROGRAM;
    localparam flash_protect_pkg::op_kind_t ERASE =
        flash_protect_pkg::OP_ERASE;
    localparam flash_protect_pkg::op_kind_t CHIP =
        flash_protect_pkg::OP_CHIP_ERASE;
    logic [22:0] s_rng, l_rng;
    assign s_rng = {s_none, s_lo, s_hi};
    assign l_rng = {l_none, l_lo, l_hi};
    always #50 sys_clk = ~sys_clk;
    flash_host_model host (.sys_clk_in(sys_clk), .op_req_out(req),
        .suspend_out(sus), .resume_out(res), .erase_busy_out(ebusy),
        .program_busy_out(pbusy));
    flash_block_protect_decode uut (.sys_clk_in(sys_clk),
        .sys_rst_in(sys_rst), .protect_code_in(code), .op_req_in(req),
        .suspend_in(sus), .resume_in(res), .erase_busy_in(ebusy),
        .program_busy_in(pbusy), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .op_accept_out(s_acc), .op_inhibit_out(s_inh), .range_lo_out(s_lo),
        .range_hi_out(s_hi), .range_none_out(s_none), .func_out(s_func));
    flash_block_protect_decode #(.LARGE_BLOCK_OPTION(1'b1),
        .RESET_DISABLE_DEFAULT(1'b1)) uut_large (.sys_clk_in(sys_clk),
        .sys_rst_in(sys_rst), .protect_code_in(code), .op_req_in(req),
        .suspend_in(sus), .resume_in(res), .erase_busy_in(ebusy),
        .program_busy_in(pbusy), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(),
        .op_accept_out(l_acc), .op_inhibit_out(l_inh), .range_lo_out(l_lo),
        .range_hi_out(l_hi), .range_none_out(l_none), .func_out(l_func));
    task automatic chk(input string what, input logic [22:0] seen,
                       input logic [22:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            results();
        end
    end
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        {rd, addr} <= {1'b1, a};
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
    endtask : rd_chk
    function automatic logic [22:0] rng(input int nb, input int c,
                                        input bit bot);
        int n;
        n = 1 << (c - 1);
        if (nb == 2048 && c >= 12)
            n = (c == 15) ? 2048 : 2048 - (512 >> (c - 12));
        if (n > nb)
            n = nb;
        return bot ? {1'b0, 11'h000, 11'(n - 1)} :
                     {1'b0, 11'(nb - n), 11'(nb - 1)};
    endfunction : rng
    task automatic sweep(input bit bot);
        for (int c = 0; c < 16; c++) begin
            @(posedge sys_clk);
            code <= c[3:0];
            repeat (3) @(posedge sys_clk);
            #1;
            if (c == 0) begin
                chk("none_s", s_none, 23'd1);
                chk("none_l", l_none, 23'd1);
            end else begin
                chk("rng_s", s_rng, rng(2048, c, bot));
                chk("rng_l", l_rng, rng(512, c, bot));
            end
        end
        $display("sweep %0d done", bot);
    endtask : sweep
    task automatic op(input flash_protect_pkg::op_kind_t k,
                      input logic [26:0] a, input logic [3:0] es,
                      input logic [3:0] el);
        host.issue(k, a);
        chk("op_s", {s_acc, s_inh}, es);
        chk("op_l", {l_acc, l_inh}, el);
    endtask : op
    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd_chk(flash_protect_pkg::ADDR_FUNC, 8'h00);
        chk("func_l", l_func, 23'h01);
        rd_chk(4'hf, 8'h00);
        sweep(1'b0);
        @(posedge sys_clk);
        code <= 4'h1;
        repeat (3) @(posedge sys_clk);
        rd_chk(flash_protect_pkg::ADDR_STATUS, 8'h01);
        // one top block protected: lo and hi both 2047
        rd_chk(flash_protect_pkg::ADDR_RANGE_LO, 8'hff);
        rd_chk(flash_protect_pkg::ADDR_RANGE_HI, 8'h77);
        // block 2046 is open at 64 KB but inside block 511 at 256 KB
        op(PROG, {11'd2047, 16'h0000}, 2'b01, 2'b01);
        op(PROG, {11'd2046, 16'hffff}, 2'b10, 2'b01);
        op(ERASE, 27'h000_0000, 2'b10, 2'b10);
        op(CHIP, 27'h000_0000, 2'b01, 2'b01);
        // the gate result is only readable in the cycle after the request
        fork
            host.issue(ERASE, 27'h7ff_0000);
            begin
                @(posedge sys_clk);
                rd_chk(flash_protect_pkg::ADDR_OP, 8'h02);
            end
        join
        @(posedge sys_clk);
        code <= 4'h0;
        repeat (3) @(posedge sys_clk);
        op(CHIP, 27'h000_0000, 2'b10, 2'b10);
        $display("gate done");
        wr_reg(flash_protect_pkg::ADDR_FUNC, 8'h02);
        wr_reg(flash_protect_pkg::ADDR_FUNC, 8'h00);
        rd_chk(flash_protect_pkg::ADDR_FUNC, 8'h02);
        sweep(1'b1);
        host.suspend(1'b0);
        chk("program_suspended_flag", s_func, 23'h06);
        host.resume();
        host.suspend(1'b1);
        chk("erase_suspended_flag", s_func, 23'h0a);
        host.resume();
        chk("resumed", s_func, 23'h02);
        // suspend flags are read-only, the rest only ever set
        wr_reg(flash_protect_pkg::ADDR_FUNC, 8'hff);
        rd_chk(flash_protect_pkg::ADDR_FUNC, 8'hf3);
        $display("function register done");
        results();
    end
endmodule : test_flash_block_protect_decode
`default_nettype wire

// ==== src/flash_block_protect_decode.sv ====
// block-protection decoder, function register and operation gate
// assumes operation requests and suspend events come from logic on
// sys_clk_in; the protection code comes from the status register owner
//
// The plain strobed port and the placing of the registers were decided locally.
`default_nettype none
// Behaviour
// - 2048 blocks of 64 KB; code zero protects nothing
// - selector zero: codes 1..11 protect 2^(code-1) blocks up to 2047
// - selector one: same count, counted upward from block 0
// - codes 12,13,14 protect 1536,1792,1920 blocks, anchored by selector
// - code 15 protects all 2048 blocks regardless of selector
// - 256 KB variant: codes 1..9 protect 2^(code-1) of 512 blocks
// - 256 KB variant: codes 101x and 11xx protect all 512 blocks
// - function register bit layout and zero defaults, bit 0 by RESET_DISABLE_DEFAULT
// - decode variant fixed by product option, not runtime setting
// - program or erase to a protected block is inhibited
// - whole-chip erase ignored unless protection code is zero
// - selector once set to one never returns to zero (here sys_rst_in clears it to zero)
// - suspend flags set on suspend, clear on resume
module flash_block_protect_decode #(
    parameter bit LARGE_BLOCK_OPTION = 1'b0,
    parameter bit RESET_DISABLE_DEFAULT = 1'b0
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // protection code from status register
    input wire logic [3:0] protect_code_in,
    // operation request and suspend events
    input var flash_protect_pkg::op_req_t op_req_in,
    input wire logic suspend_in,
    input wire logic resume_in,
    input wire logic erase_busy_in,
    input wire logic program_busy_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // results
    output logic op_accept_out,
    output logic op_inhibit_out,
    output logic [10:0] range_lo_out,
    output logic [10:0] range_hi_out,
    output logic range_none_out,
    output var flash_protect_pkg::func_reg_t func_out
);
    localparam int unsigned NBLK = LARGE_BLOCK_OPTION ?
        flash_protect_pkg::LARGE_BLOCKS : flash_protect_pkg::SMALL_BLOCKS;

    // protected block count for a code, per fixed variant
    function automatic logic [11:0] prot_count(input logic [3:0] code);
        logic [11:0] n;
        n = 12'h000;
        if (code == flash_protect_pkg::CODE_NONE) begin
            n = 12'h000;
        end else if (LARGE_BLOCK_OPTION) begin
            if (code >= 4'ha) begin
                n = 12'd512;
            end else begin
                n = 12'(12'h001 << (code - 4'h1));
            end
        end else begin
            unique case (code)
                4'hc: n = 12'd1536;
                4'hd: n = 12'd1792;
                4'he: n = 12'd1920;
                4'hf: n = 12'd2048;
                default: n = 12'(12'h001 << (code - 4'h1));
            endcase
        end
        return n;
    endfunction : prot_count

    // block index from upper address bits
    function automatic logic [10:0] block_of(input logic [26:0] a);
        logic [10:0] b;
        if (LARGE_BLOCK_OPTION) begin
            b = {2'b00, a[26:flash_protect_pkg::LARGE_SHIFT]};
        end else begin
            b = a[26:flash_protect_pkg::SMALL_SHIFT];
        end
        return b;
    endfunction : block_of

    flash_protect_pkg::func_reg_t func, next_func;
    logic [7:0] rdata, next_rdata;
    logic accept, next_accept;
    logic inhibit, next_inhibit;
    logic [10:0] lo, hi, next_lo, next_hi;
    logic none_r, next_none;
    logic [11:0] cnt;
    logic [10:0] blk;
    logic protected_hit;

    // range decode; top anchor unless selector set
    always_comb begin
        cnt = prot_count(protect_code_in);
        next_none = (cnt == 12'h000);
        if (next_none) begin
            next_lo = 11'h000;
            next_hi = 11'h000;
        end else if (func.top_bottom_select) begin
            next_lo = 11'h000;
            next_hi = 11'(cnt - 12'h001);
        end else begin
            next_lo = 11'(12'(NBLK) - cnt);
            next_hi = 11'(NBLK - 1);
        end
    end

    always_comb begin
        blk = block_of(op_req_in.addr);
        protected_hit = !next_none && blk >= next_lo && blk <= next_hi;
        next_accept = 1'b0;
        next_inhibit = 1'b0;
        if (op_req_in.valid) begin
            unique case (op_req_in.kind)
                flash_protect_pkg::OP_CHIP_ERASE: begin
                    next_accept = (protect_code_in ==
                        flash_protect_pkg::CODE_NONE);
                    next_inhibit = !next_accept;
                end
                flash_protect_pkg::OP_PROGRAM,
                flash_protect_pkg::OP_ERASE: begin
                    next_accept = !protected_hit;
                    next_inhibit = protected_hit;
                end
                flash_protect_pkg::OP_NONE: begin
                    next_accept = 1'b0;
                end
            endcase
        end
    end

    // function register: otp bits only move to one until sys_rst_in reloads FUNC_RESET, bit 0 from RESET_DISABLE_DEFAULT; suspend wins over resume
    always_comb begin
        next_func = func;
        if (reg_wr_in && reg_addr_in == flash_protect_pkg::ADDR_FUNC) begin
            next_func.info_row_lock = func.info_row_lock |
                reg_wdata_in[flash_protect_pkg::FUNC_IRL_LSB +: 4];
            next_func.top_bottom_select = func.top_bottom_select |
                reg_wdata_in[flash_protect_pkg::FUNC_TBS_BIT];
            next_func.reset_pin_disable = func.reset_pin_disable |
                reg_wdata_in[flash_protect_pkg::FUNC_RSTDIS_BIT];
        end
        if (resume_in) begin
            next_func.program_suspended_flag = 1'b0;
            next_func.erase_suspended_flag = 1'b0;
        end
        if (suspend_in && program_busy_in) begin
            next_func.program_suspended_flag = 1'b1;
        end
        if (suspend_in && erase_busy_in) begin
            next_func.erase_suspended_flag = 1'b1;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                flash_protect_pkg::ADDR_FUNC: next_rdata = func;
                flash_protect_pkg::ADDR_STATUS:
                    next_rdata = {4'h0, protect_code_in};
                flash_protect_pkg::ADDR_RANGE_LO: next_rdata = lo[7:0];
                flash_protect_pkg::ADDR_RANGE_HI:
                    next_rdata = {none_r, hi[10:8], 1'b0, lo[10:8]};
                flash_protect_pkg::ADDR_OP:
                    next_rdata = {6'h00, inhibit, accept};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            func <= flash_protect_pkg::FUNC_RESET;
            func.reset_pin_disable <= RESET_DISABLE_DEFAULT;
            rdata <= 8'h00;
            accept <= 1'b0;
            inhibit <= 1'b0;
            lo <= 11'h000;
            hi <= 11'h000;
            none_r <= 1'b1;
        end else begin
            func <= next_func;
            rdata <= next_rdata;
            accept <= next_accept;
            inhibit <= next_inhibit;
            lo <= next_lo;
            hi <= next_hi;
            none_r <= next_none;
        end
    end

    assign reg_rdata_out = rdata;
    assign op_accept_out = accept;
    assign op_inhibit_out = inhibit;
    assign range_lo_out = lo;
    assign range_hi_out = hi;
    assign range_none_out = none_r;
    assign func_out = func;

    property p_tbs_sticky;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        func.top_bottom_select |=> func.top_bottom_select;
    endproperty
    a_tbs_sticky: assert property (p_tbs_sticky)
        else $error("selector returned to zero");

    property p_chip_erase_gate;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        op_req_in.valid && op_req_in.kind == flash_protect_pkg::OP_CHIP_ERASE
        && protect_code_in != 4'h0 |=> inhibit && !accept;
    endproperty
    a_chip_erase_gate: assert property (p_chip_erase_gate)
        else $error("chip erase not refused");

    property p_code_zero;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        protect_code_in == 4'h0 |=> none_r;
    endproperty
    a_code_zero: assert property (p_code_zero)
        else $error("code zero protects blocks");

    property p_code_all;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        protect_code_in == 4'hf |=> lo == 11'h000 && hi == 11'(NBLK - 1);
    endproperty
    a_code_all: assert property (p_code_all)
        else $error("code fifteen not whole array");

    property p_top_end;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        protect_code_in != 4'h0 && !func.top_bottom_select
        |=> hi == 11'(NBLK - 1);
    endproperty
    a_top_end: assert property (p_top_end)
        else $error("top range not ending at last block");

    property p_bottom_start;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        func.top_bottom_select |=> lo == 11'h000;
    endproperty
    a_bottom_start: assert property (p_bottom_start)
        else $error("bottom range not starting at block zero");

    property p_inhibit_hit;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        op_req_in.valid && op_req_in.kind == flash_protect_pkg::OP_PROGRAM
        && protected_hit |=> (inhibit && !accept)
        ##1 (!inhibit || $past(op_req_in.valid));
    endproperty
    a_inhibit_hit: assert property (p_inhibit_hit)
        else $error("protected program not inhibited");

    property p_program_suspended_flag_set;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        suspend_in && program_busy_in |=> func.program_suspended_flag;
    endproperty
    a_program_suspended_flag_set: assert property (p_program_suspended_flag_set)
        else $error("program suspend flag not set");

    property p_sus_clear;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        resume_in && !suspend_in |=> !func.program_suspended_flag
            && !func.erase_suspended_flag;
    endproperty
    a_sus_clear: assert property (p_sus_clear)
        else $error("suspend flag not cleared on resume");

    c_chip_erase_ok: cover property (@(posedge sys_clk_in)
        accept && $past(op_req_in.kind) == flash_protect_pkg::OP_CHIP_ERASE);
    c_inhibit: cover property (@(posedge sys_clk_in) inhibit);
    c_bottom: cover property (@(posedge sys_clk_in)
        func.top_bottom_select && !none_r);
endmodule : flash_block_protect_decode
`default_nettype wire

// ==== src/flash_protect_pkg.sv ====
// constants and carriers for the block-protection decoder
// assumes a single 10 MHz system clock and synchronous reset
`default_nettype none
package flash_protect_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    // register map of the plain register port
    localparam logic [3:0] ADDR_FUNC = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_RANGE_LO = 4'h2;
    localparam logic [3:0] ADDR_RANGE_HI = 4'h3;
    localparam logic [3:0] ADDR_OP = 4'h4;
    // function register field positions
    localparam int unsigned FUNC_IRL_LSB = 4;
    localparam int unsigned FUNC_ERASE_SUSPENDED_FLAG_BIT = 3;
    localparam int unsigned FUNC_PROGRAM_SUSPENDED_FLAG_BIT = 2;
    localparam int unsigned FUNC_TBS_BIT = 1;
    localparam int unsigned FUNC_RSTDIS_BIT = 0;
    localparam logic [7:0] FUNC_RESET = 8'h00;
    // array geometry
    localparam int unsigned SMALL_BLOCKS = 2048;
    localparam int unsigned LARGE_BLOCKS = 512;
    localparam int unsigned SMALL_SHIFT = 16;
    localparam int unsigned LARGE_SHIFT = 18;
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_ALL = 4'hf;

    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_PROGRAM = 2'h1,
        OP_ERASE = 2'h3,
        OP_CHIP_ERASE = 2'h2
    } op_kind_t;

    typedef struct packed {
        logic [3:0] info_row_lock;
        logic erase_suspended_flag;
        logic program_suspended_flag;
        logic top_bottom_select;
        logic reset_pin_disable;
    } func_reg_t;

    typedef struct packed {
        logic valid;
        op_kind_t kind;
        logic [26:0] addr;
    } op_req_t;
endpackage : flash_protect_pkg
`default_nettype wire
